// [src/pci_irq_input_router.v]
// Functional notes
// - Slot 1-8 INTA land on inputs 6-13, INTB on inputs 16-23.
// - Redirection has 48 entries: 16 legacy, 32 PCI.
// - Entries are three identical 16-entry redirection units.
// - Every PCI input can be routed to any legacy line.
// - Routed PCI requests drive the legacy controller request lines.
// - Serial cycle is start frame, at least 17 slots, stop frame.
// - In quiet mode a peripheral may start a cycle; host follows.
// - In continuous mode the host drives every start frame.
// - Up to 32 slots per cycle; default count is 17.
// - Reset returns the block to legacy mode.
// - Legacy mode: power button raises SMI.
// - ACPI mode: power button raises SCI.
// - Sleep button ignored outside ACPI; in ACPI while running raises SCI.
// - Legacy wake enable resets disabled.
`timescale 1ns/1ps
`default_nettype none
`include "pci_irq_input_defines.vh"

module pci_irq_input_router #(
    parameter SLOTS = `PCI_IRQ_INPUT_SER_MIN_SLOTS
) (
    // Clock and reset
    input  wire                          ref_clk,
    input  wire                          reset,
    // Onboard PCI sources on their inputs (slot positions ignored here)
    input  wire [`PCI_IRQ_INPUT_PCI_INPUTS-1:0]   pci_irq_input,
    // Slot interrupt lines
    input  wire [`PCI_IRQ_INPUT_SLOT_COUNT-1:0]   slot_inta,
    input  wire [`PCI_IRQ_INPUT_SLOT_COUNT-1:0]   slot_intb,
    // Direct legacy sources
    input  wire [`PCI_IRQ_INPUT_LEGACY_LINES-1:0] legacy_src,
    // Routing field write
    input  wire                          route_we,
    input  wire [5:0]                    route_idx,
    input  wire [`PCI_IRQ_INPUT_ROUTE_W-1:0]      route_val,
    // Serial channel pin and mode
    input  wire                          ser_in,
    output reg                           ser_out_ff,
    output reg                           ser_oe_ff,
    input  wire                          ser_continuous,
    // Serial PCI scan stream from external serializer
    input  wire                          scan_frame,
    input  wire                          scan_data,
    // Mode and buttons
    input  wire                          acpi_enable_set,
    input  wire                          acpi_enable_clr,
    input  wire                          sys_running,
    input  wire                          power_button,
    input  wire                          sleep_button,
    input  wire                          legacy_wake_set,
    input  wire                          legacy_wake_clr,
    // Outputs
    output reg  [`PCI_IRQ_INPUT_LEGACY_LINES-1:0] legacy_irq_ff,
    output reg  [`PCI_IRQ_INPUT_PCI_INPUTS-1:0]   scan_irq_ff,
    output reg                           acpi_mode_ff,
    output reg                           legacy_wake_en_ff,
    output reg                           smi_ff,
    output reg                           sci_ff,
    output reg                           ser_busy_ff
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_START = 3'h1;
    localparam ST_SLOT  = 3'h2;
    localparam ST_STOP  = 3'h3;
    localparam ST_GAP   = 3'h4;

    // Merge slot lines into their fixed input positions.
    reg [`PCI_IRQ_INPUT_PCI_INPUTS-1:0] pci_all;
    integer k;
    always @*
    begin
        pci_all = pci_irq_input | scan_irq_ff;
        for (k = 0; k < `PCI_IRQ_INPUT_SLOT_COUNT; k = k + 1)
        begin
            pci_all[`PCI_IRQ_INPUT_SLOT_INTA_BASE + k] = slot_inta[k];
            pci_all[`PCI_IRQ_INPUT_SLOT_INTB_BASE + k] = slot_intb[k];
        end
    end

    // Serial IRQ slot captures 0-15 become legacy requests too.
    reg [`PCI_IRQ_INPUT_SER_MAX_SLOTS-1:0] ser_irq_ff;

    // Unit 0 holds the 16 legacy entries, units 1-2 the 32 PCI entries.
    wire [`PCI_IRQ_INPUT_UNIT_ENTRIES*`PCI_IRQ_INPUT_UNIT_COUNT-1:0] ent_req;
    assign ent_req = {pci_all, legacy_src | ser_irq_ff[15:0]};
    wire [`PCI_IRQ_INPUT_LEGACY_LINES*`PCI_IRQ_INPUT_UNIT_COUNT-1:0] unit_lines;

    genvar u;
    generate
        for (u = 0; u < `PCI_IRQ_INPUT_UNIT_COUNT; u = u + 1)
        begin : g_unit
            pci_irq_input_redirect_unit #(
                .ENTRIES   (`PCI_IRQ_INPUT_UNIT_ENTRIES)
            ) u_unit (
                .ref_clk   (ref_clk),
                .reset     (reset),
                .req_in    (ent_req[u*16 +: 16]),
                .cfg_we    (route_we && route_idx[5:4] == u),
                .cfg_idx   (route_idx[3:0]),
                .cfg_route (route_val),
                .line_req  (unit_lines[u*16 +: 16])
            );
        end
    endgenerate

    always @(posedge ref_clk)
    begin
        if (reset)
            legacy_irq_ff <= 16'h0000;
        else
            legacy_irq_ff <= unit_lines[15:0] | unit_lines[31:16]
                           | unit_lines[47:32];
    end

    // External serializer shifts 32 requests per frame, bit 0 first.
    // Bits are only taken after a frame pulse, so an idle stream between
    // scans cannot be latched as interrupt requests.
    reg [4:0]  scan_cnt_ff;
    reg [31:0] scan_sh_ff;
    reg        scan_run_ff;
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            scan_cnt_ff <= 5'h00;
            scan_sh_ff  <= 32'h00000000;
            scan_irq_ff <= 32'h00000000;
            scan_run_ff <= 1'b0;
        end
        else if (scan_frame)
        begin
            scan_cnt_ff <= 5'h00;
            scan_run_ff <= 1'b1;
        end
        else if (scan_run_ff)
        begin
            scan_sh_ff[scan_cnt_ff] <= scan_data;
            scan_cnt_ff <= scan_cnt_ff + 5'h01;
            if (scan_cnt_ff == 5'h1F)
            begin
                scan_irq_ff <= {scan_data, scan_sh_ff[30:0]};
                scan_run_ff <= 1'b0;
            end
        end
    end

    // Serial IRQ host: start frame, slots of three phases, stop frame.
    // A slot is active when the peripheral pulls the line low in phase 0.
    reg [2:0] st_ff;
    reg [2:0] nxt_st;
    reg [5:0] cnt_ff;
    reg [1:0] ph_ff;
    reg       ser_in_d_ff;
    reg [`PCI_IRQ_INPUT_SER_MAX_SLOTS-1:0] ser_acc_ff;

    always @*
    begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE:
                if (ser_continuous || (!ser_in && ser_in_d_ff))
                    nxt_st = ST_START;
            ST_START:
                if (cnt_ff == `PCI_IRQ_INPUT_SER_START_LEN - 1)
                    nxt_st = ST_SLOT;
            ST_SLOT:
                if (cnt_ff == SLOTS - 1 && ph_ff == `PCI_IRQ_INPUT_SLOT_PHASES - 1)
                    nxt_st = ST_STOP;
            ST_STOP:
                if (cnt_ff == `PCI_IRQ_INPUT_SER_STOP_LEN - 1)
                    nxt_st = ST_GAP;
            ST_GAP:
                if (cnt_ff == `PCI_IRQ_INPUT_SER_IDLE_LEN - 1)
                    nxt_st = ST_IDLE;
            default:
                nxt_st = ST_IDLE;
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            st_ff       <= ST_IDLE;
            cnt_ff      <= 6'h00;
            ph_ff       <= 2'h0;
            ser_in_d_ff <= 1'b1;
            ser_out_ff  <= 1'b1;
            ser_oe_ff   <= 1'b0;
            ser_acc_ff  <= 32'h00000000;
            ser_irq_ff  <= 32'h00000000;
            ser_busy_ff <= 1'b0;
        end
        else
        begin
            ser_in_d_ff <= ser_in;
            st_ff       <= nxt_st;
            ser_busy_ff <= (nxt_st != ST_IDLE);
            if (nxt_st != st_ff)
            begin
                cnt_ff <= 6'h00;
                ph_ff  <= 2'h0;
            end
            else if (st_ff == ST_SLOT)
            begin
                if (ph_ff == `PCI_IRQ_INPUT_SLOT_PHASES - 1)
                begin
                    ph_ff  <= 2'h0;
                    cnt_ff <= cnt_ff + 6'h01;
                end
                else
                    ph_ff <= ph_ff + 2'h1;
            end
            else
                cnt_ff <= cnt_ff + 6'h01;
            // Host drives start low, stop low, otherwise releases the line.
            ser_out_ff <= !(nxt_st == ST_START || nxt_st == ST_STOP);
            ser_oe_ff  <= (nxt_st == ST_START || nxt_st == ST_STOP);
            if (st_ff == ST_START)
                ser_acc_ff <= 32'h00000000;
            if (st_ff == ST_SLOT && ph_ff == 2'h0)
                ser_acc_ff[cnt_ff[4:0]] <= !ser_in;
            if (st_ff == ST_SLOT && nxt_st == ST_STOP)
                ser_irq_ff <= ser_acc_ff;
        end
    end

    // Mode, wake enable and button events.
    // Press edges are used so a held button gives one event.
    reg pwr_d_ff;
    reg slp_d_ff;
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            acpi_mode_ff      <= 1'b0;
            legacy_wake_en_ff <= 1'b0;
            pwr_d_ff          <= 1'b0;
            slp_d_ff          <= 1'b0;
            smi_ff            <= 1'b0;
            sci_ff            <= 1'b0;
        end
        else
        begin
            pwr_d_ff <= power_button;
            slp_d_ff <= sleep_button;
            if (acpi_enable_set)
                acpi_mode_ff <= 1'b1;
            else if (acpi_enable_clr)
                acpi_mode_ff <= 1'b0;
            if (legacy_wake_set)
                legacy_wake_en_ff <= 1'b1;
            else if (legacy_wake_clr)
                legacy_wake_en_ff <= 1'b0;
            smi_ff <= power_button && !pwr_d_ff && !acpi_mode_ff;
            sci_ff <= (power_button && !pwr_d_ff && acpi_mode_ff)
                   || (sleep_button && !slp_d_ff && acpi_mode_ff
                       && sys_running);
        end
    end
endmodule
`default_nettype wire

// [include/pci_irq_input_defines.vh]
`ifndef PCI_IRQ_INPUT_DEFINES_VH
`define PCI_IRQ_INPUT_DEFINES_VH

// PCI input positions of slot lines.
`define PCI_IRQ_INPUT_SLOT_INTA_BASE 6
`define PCI_IRQ_INPUT_SLOT_INTB_BASE 16
`define PCI_IRQ_INPUT_SLOT_COUNT     8

// Redirection structure sizing.
`define PCI_IRQ_INPUT_UNIT_ENTRIES   16
`define PCI_IRQ_INPUT_UNIT_COUNT     3
`define PCI_IRQ_INPUT_LEGACY_LINES   16
`define PCI_IRQ_INPUT_PCI_INPUTS     32

// Routing field: bit 4 set means disabled, low bits select legacy line.
`define PCI_IRQ_INPUT_ROUTE_W        5
`define PCI_IRQ_INPUT_ROUTE_DIS      5'h10

// Serial channel framing: slot counts, and lengths in clock cycles.
`define PCI_IRQ_INPUT_SER_MIN_SLOTS  17
`define PCI_IRQ_INPUT_SER_MAX_SLOTS  32
`define PCI_IRQ_INPUT_SER_START_LEN  4
`define PCI_IRQ_INPUT_SER_STOP_LEN   2
`define PCI_IRQ_INPUT_SER_IDLE_LEN   2
`define PCI_IRQ_INPUT_SLOT_PHASES    3

`endif

// [src/pci_irq_input_redirect_unit.v]
`timescale 1ns/1ps
`default_nettype none
`include "pci_irq_input_defines.vh"

module pci_irq_input_redirect_unit #(
    parameter ENTRIES = 16
) (
    // Clock and reset
    input  wire                          ref_clk,
    input  wire                          reset,
    // Entry requests
    input  wire [ENTRIES-1:0]            req_in,
    // Routing table write
    input  wire                          cfg_we,
    input  wire [3:0]                    cfg_idx,
    input  wire [`PCI_IRQ_INPUT_ROUTE_W-1:0]      cfg_route,
    // Per-line requests from this unit
    output wire [`PCI_IRQ_INPUT_LEGACY_LINES-1:0] line_req
);
    reg [`PCI_IRQ_INPUT_ROUTE_W-1:0] route_ff [0:ENTRIES-1];
    reg [`PCI_IRQ_INPUT_LEGACY_LINES-1:0] acc;
    integer i;

    genvar g;
    generate
        for (g = 0; g < ENTRIES; g = g + 1)
        begin : g_ent
            always @(posedge ref_clk)
            begin
                if (reset)
                    route_ff[g] <= `PCI_IRQ_INPUT_ROUTE_DIS;
                else if (cfg_we && cfg_idx == g)
                    route_ff[g] <= cfg_route;
            end
        end
    endgenerate

    // Shared targets are ORed so no source can mask another.
    always @*
    begin
        acc = {`PCI_IRQ_INPUT_LEGACY_LINES{1'b0}};
        for (i = 0; i < ENTRIES; i = i + 1)
            if (req_in[i] && !route_ff[i][4])
                acc[route_ff[i][3:0]] = 1'b1;
    end
    assign line_req = acc;
endmodule
`default_nettype wire

// [tb/pirsi_chk_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module pirsi_chk (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        reset,
    // Inputs watched
    input wire logic        sys_running,
    input wire logic        power_button,
    input wire logic        sleep_button,
    input wire logic        ser_continuous,
    // Outputs watched
    input wire logic        ser_out_ff,
    input wire logic        ser_oe_ff,
    input wire logic        ser_busy_ff,
    input wire logic        acpi_mode_ff,
    input wire logic        legacy_wake_en_ff,
    input wire logic        smi_ff,
    input wire logic        sci_ff,
    input wire logic [15:0] legacy_irq_ff
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_reset_mode: assert property ($fell(reset) |-> !acpi_mode_ff && !legacy_wake_en_ff
        && legacy_irq_ff == 16'h0000) else $error("reset left state set");
    a_legacy_no_sci: assert property (!acpi_mode_ff |=> !sci_ff)
        else $error("sci in legacy mode");
    a_acpi_no_smi: assert property (acpi_mode_ff |=> !smi_ff)
        else $error("smi in acpi mode");
    a_power_smi: assert property (!acpi_mode_ff && $rose(power_button) |=> smi_ff)
        else $error("no smi");
    a_power_sci: assert property (acpi_mode_ff && $rose(power_button) |=> sci_ff)
        else $error("no sci for power");
    a_sleep_sci: assert property
        (acpi_mode_ff && sys_running && $rose(sleep_button) |=> sci_ff) else $error("no sci");
    a_smi_pulse: assert property (smi_ff |=> !smi_ff)
        else $error("smi too long");
    a_cont_start: assert property (ser_continuous && !ser_busy_ff |-> ##[0:8] ser_oe_ff)
        else $error("no start frame");
    a_drive_low: assert property (ser_oe_ff |-> !ser_out_ff)
        else $error("line driven high");
endmodule
bind pci_irq_input_router pirsi_chk u_chk (.ref_clk, .reset, .sys_running, .power_button, .sleep_button,
    .ser_continuous, .ser_out_ff, .ser_oe_ff, .ser_busy_ff, .acpi_mode_ff, .legacy_wake_en_ff,
    .smi_ff, .sci_ff, .legacy_irq_ff);
`default_nettype wire

// [tb/pirsi_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module pirsi_peer #(
    parameter SLOT = 5
) (
    // Clock
    input  wire logic        ref_clk,
    // Serial line
    input  wire logic        line,
    input  wire logic        kick,
    input  wire logic        slot_en,
    output var logic         drv_n,
    // Scan stream
    input  wire logic        scan_go,
    input  wire logic [31:0] scan_word,
    output var logic         scan_frame,
    output var logic         scan_data
);
    logic [1:0] low_cnt = 2'd0;
    logic       in_frame = 1'b0;
    logic [7:0] cyc = 8'd0;
    logic [5:0] bit_n = 6'd32;
    initial drv_n = 1'b1;
    initial scan_frame = 1'b0;
    initial scan_data = 1'b0;
    // Only lows made by others count, so our own slot drive never looks like a frame.
    always @(negedge ref_clk)
    begin
        low_cnt <= (line || !drv_n) ? 2'd0 : low_cnt + {1'b0, low_cnt != 2'd3};
        if (line && low_cnt >= 2'd2)
        begin
            in_frame <= !in_frame;
            cyc <= 8'd0;
        end
        else
            cyc <= cyc + 8'd1;
        drv_n <= !(kick || (in_frame && slot_en && cyc + 8'd2 >= 3 * SLOT && cyc <= 3 * SLOT));
        scan_frame <= scan_go;
        bit_n <= scan_go ? 6'd0 : bit_n + {5'd0, bit_n != 6'd32};
        // Outside a scan the data line toggles, so a stale bit cannot pass.
        scan_data <= (scan_go || bit_n[5]) ? !scan_data : scan_word[bit_n[4:0]];
    end
endmodule
`default_nettype wire

// [tb/pci_irq_router_serial_irq_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pci_irq_input_defines.vh"
module pci_irq_router_serial_irq_tb;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic [31:0] pci_in = 32'h0;
    logic [7:0]  inta = 8'h00;
    logic [7:0]  intb = 8'h00;
    logic [15:0] leg_src = 16'h0000;
    logic        we = 1'b0;
    logic [5:0]  idx = 6'h00;
    logic [4:0]  val = 5'h00;
    logic [6:0]  ctl = 7'h00;
    logic        cont = 1'b0;
    logic        kick = 1'b0;
    logic        slot_en = 1'b0;
    logic        go = 1'b0;
    wire         s_out, s_oe, busy, acpi, wake, smi, sci, drv_n, sf, sd;
    wire [15:0]  irq;
    wire [31:0]  scan;
    wire         line = !(s_oe && !s_out) && drv_n;
    int          fails = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          n;
    int          gap;
    pci_irq_input_router dut (
        .ref_clk, .reset, .pci_irq_input(pci_in), .slot_inta(inta), .slot_intb(intb),
        .legacy_src(leg_src), .route_we(we), .route_idx(idx), .route_val(val), .ser_in(line),
        .ser_out_ff(s_out), .ser_oe_ff(s_oe), .ser_continuous(cont), .scan_frame(sf),
        .scan_data(sd), .acpi_enable_set(ctl[0]), .acpi_enable_clr(ctl[1]),
        .sys_running(ctl[2]), .power_button(ctl[3]), .sleep_button(ctl[4]),
        .legacy_wake_set(ctl[5]), .legacy_wake_clr(ctl[6]), .legacy_irq_ff(irq),
        .scan_irq_ff(scan), .acpi_mode_ff(acpi), .legacy_wake_en_ff(wake), .smi_ff(smi),
        .sci_ff(sci), .ser_busy_ff(busy)
    );
    pirsi_peer peer (.ref_clk, .line, .kick, .slot_en, .drv_n, .scan_go(go),
        .scan_word(32'hA5C30F81), .scan_frame(sf), .scan_data(sd));
    always #10 ref_clk = !ref_clk;
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            fails++;
            finish_test;
        end
    end
    task automatic tick(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic route(input int i, input int v);
        idx = i[5:0];
        val = v[4:0];
        we = 1'b1;
        tick(1);
        we = 1'b0;
        tick(1);
    endtask
    // Counts smi pulses times 16 plus sci pulses seen while the input is held.
    task automatic press(input int b);
        n = 0;
        ctl[b] = 1'b1;
        repeat (4)
        begin
            tick(1);
            n += 16 * (smi === 1'b1) + (sci === 1'b1);
        end
        ctl[b] = 1'b0;
        tick(1);
    endtask
    task automatic frame(output int g);
        g = 0;
        for (int t = 0; t < 200 && s_oe !== 1'b1; t++)
            tick(1);
        for (int t = 0; t < 200 && s_oe === 1'b1; t++)
            tick(1);
        for (int t = 0; t < 200 && s_oe !== 1'b1; t++)
        begin
            tick(1);
            g++;
        end
    endtask
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        tick(2);
        reset = 1'b0;
        tick(1);
        chk({acpi, wake, irq}, 0);
        for (int s = 0; s < 8; s++)
        begin
            route(22 + s, s);
            route(32 + s, 8 + s);
        end
        for (int s = 0; s < 8; s++)
        begin
            inta = 8'h01 << s;
            intb = 8'h80 >> s;
            tick(2);
            chk(irq, (1 << s) | (32'h100 << (7 - s)));
        end
        inta = 8'h00;
        intb = 8'h00;
        route(47, 9);
        route(16, 9);
        route(2, 2);
        pci_in = 32'h80000001;
        leg_src = 16'h0004;
        tick(2);
        chk(irq, 32'h0204);
        pci_in = 32'h00000001;
        tick(2);
        chk(irq, 32'h0204);
        route(16, `PCI_IRQ_INPUT_ROUTE_DIS);
        tick(1);
        chk(irq, 32'h0004);
        press(3);
        chk(n, 32'h10);
        press(4);
        chk(n, 0);
        press(0);
        press(3);
        chk(n, 32'h01);
        press(4);
        chk(n, 0);
        ctl[2] = 1'b1;
        press(4);
        chk(n, 32'h01);
        press(5);
        chk({acpi, wake}, 3);
        reset = 1'b1;
        tick(2);
        reset = 1'b0;
        tick(1);
        chk({acpi, wake}, 0);
        route(5, 5);
        slot_en = 1'b1;
        kick <= 1'b1;
        tick(2);
        kick <= 1'b0;
        frame(gap);
        chk(gap, 3 * `PCI_IRQ_INPUT_SER_MIN_SLOTS);
        tick(8);
        chk(irq, 32'h0020);
        cont = 1'b1;
        frame(gap);
        chk(gap, 3 * `PCI_IRQ_INPUT_SER_MIN_SLOTS);
        cont = 1'b0;
        tick(70);
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        tick(34);
        chk(scan, 32'hA5C30F81);
        finish_test;
    end
endmodule
`default_nettype wire
